// [shared/timer_pkg.sv]
// constants shared by the prescaled 16-bit timer/counter
package timer_pkg;

  // register byte addresses on the apb bus
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_COUNT_LOW = 12'h004;
  localparam logic [11:0] ADDR_COUNT_HIGH = 12'h008;
  localparam logic [11:0] ADDR_STATUS = 12'h00C;
  localparam logic [11:0] ADDR_IRQ_ENABLE = 12'h010;

  // timer_control field positions
  localparam int BIT_WIDE_ACCESS_MODE = 7;
  localparam int BIT_CMP_CAP_TIMER_SEL_HI = 6;
  localparam int BIT_PRESCALE_SEL_HI = 5;
  localparam int BIT_PRESCALE_SEL_LO = 4;
  localparam int BIT_CMP_CAP_TIMER_SEL_LO = 3;
  localparam int BIT_EXT_SYNC_DISABLE = 2;
  localparam int BIT_CLOCK_SOURCE_SEL = 1;
  localparam int BIT_TIMER_RUN = 0;

  // status and enable field positions
  localparam int BIT_OVERFLOW_FLAG = 0;
  localparam int BIT_OVERFLOW_IRQ_ENABLE = 0;

  // values after reset
  localparam logic [7:0] TIMER_CONTROL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] HIGH_BUFFER_RESET = 8'h00;

  // all-ones count at which the next step wraps
  localparam logic [15:0] COUNT_ALL_ONES = 16'hFFFF;

  // instruction cycle is the pclk oscillator divided by this count
  localparam int INSTR_CLK_DIV = 4;
  localparam logic [1:0] INSTR_DIV_LAST = 2'(INSTR_CLK_DIV - 1);

  // compare mode code that fires the special event trigger
  localparam logic [3:0] SPECIAL_EVENT_MODE = 4'hB;

endpackage

// [hw/ext_edge_detect.sv]
// external count clock edge detector with optional synchroniser
module ext_edge_detect
  import timer_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic enable,
  input wire logic bypass_sync,
  // count clock
  input wire logic raw_clock,
  // result
  output logic rise
);

  logic sync_stage1;
  logic sync_stage2;
  logic direct_sample;
  logic level_prev;
  logic armed;
  logic level;

  // two-flop path, first stage read only by the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_stage1 <= 1'b0;
      sync_stage2 <= 1'b0;
    end else begin
      sync_stage1 <= raw_clock;
      sync_stage2 <= sync_stage1;
    end
  end

  // unsynchronised path: a single sample, less latency but no metastability filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direct_sample <= 1'b0;
    end else begin
      direct_sample <= raw_clock;
    end
  end

  assign level = bypass_sync ? direct_sample : sync_stage2;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_prev <= 1'b0;
    end else begin
      level_prev <= level;
    end
  end

  // a rising edge counts only once a falling edge has been seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed <= 1'b0;
    end else if (!enable) begin
      armed <= 1'b0;
    end else if (level_prev && !level) begin
      armed <= 1'b1;
    end
  end

  assign rise = enable && armed && level && !level_prev;

endmodule

// [hw/timer_counter.sv]
// prescaled 16-bit timer/counter with apb register access
//
// Behaviour
// - count held as high and low bytes
// - both count bytes readable and writable anytime
// - overflow event when count wraps to zero
// - counter reset input from capture/compare trigger
// - after reset timer off, control zero
// - bit 7 selects 16-bit or 8-bit access
// - select 1x routes this timer to both
// - prescale field divides by 8, 4, 2, 1
// - bit 2 set skips external clock synchronisation
// - sync bit ignored with internal clock
// - clock source bit picks operating mode
// - internal source counts every instruction cycle
// - external source counts on rising edges
// - bit 0 runs or stops the counter
// - oscillator enable forces both pins to inputs
// - oscillator enable comes from other timer
// - latched overflow flag, interrupt only when enabled
// - special event compare match clears counter
// - special event reset leaves overflow flag alone
// - software count write beats special event reset
//
// Added by the designer: the placing of the registers and the APB slave port.
module timer_counter
  import timer_pkg::*;
(
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // external count clock and oscillator
  input wire logic ext_count_input,
  input wire logic osc_in_pin,
  input wire logic low_power_osc_enable,
  output logic osc_pins_force_input,
  // capture/compare units
  input wire logic [3:0] capture_compare_mode_code,
  input wire logic compare_match,
  output logic [15:0] count_value,
  output logic ccp_uses_this_timer,
  output logic eccp_uses_this_timer,
  // overflow
  output logic overflow_irq
);

  logic [7:0] timer_control;
  logic [15:0] count;
  logic [7:0] high_buffer;
  logic overflow_flag;
  logic overflow_irq_enable;
  logic [2:0] prescale_count;
  logic [1:0] instr_div;
  logic instr_tick;
  logic ext_rise;
  logic source_tick;
  logic count_step;
  logic special_event;
  logic wide_mode;
  logic ext_source;
  logic setup_phase;
  logic write_done;
  logic wr_low;
  logic wr_high;
  logic wr_status;
  logic rd_low_setup;
  logic [15:0] next_count;
  logic [31:0] next_prdata;
  logic next_slverr;
  logic [2:0] next_prescale;

  // prescale code to a mask of the low prescaler bits
  function automatic logic [2:0] prescale_mask(input logic [1:0] code);
    unique case (code)
      2'b00: prescale_mask = 3'h0;
      2'b01: prescale_mask = 3'h1;
      2'b10: prescale_mask = 3'h3;
      2'b11: prescale_mask = 3'h7;
    endcase
  endfunction

  // true when the address names a mapped register
  function automatic logic addr_mapped(input logic [11:0] addr);
    addr_mapped = (addr == ADDR_CONTROL) || (addr == ADDR_COUNT_LOW) ||
                  (addr == ADDR_COUNT_HIGH) || (addr == ADDR_STATUS) ||
                  (addr == ADDR_IRQ_ENABLE);
  endfunction

  assign wide_mode = timer_control[BIT_WIDE_ACCESS_MODE];
  assign ext_source = timer_control[BIT_CLOCK_SOURCE_SEL];

  // apb decode
  assign setup_phase = psel && !penable;
  assign write_done = psel && penable && pready && pwrite;
  assign wr_low = write_done && (paddr == ADDR_COUNT_LOW);
  assign wr_high = write_done && (paddr == ADDR_COUNT_HIGH);
  assign wr_status = write_done && (paddr == ADDR_STATUS);
  assign rd_low_setup = setup_phase && !pwrite && (paddr == ADDR_COUNT_LOW);

  // one wait-free access phase: answer is ready in the cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else begin
      pready <= setup_phase;
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_slverr = !addr_mapped(paddr);
    if (!pwrite) begin
      unique case (paddr)
        ADDR_CONTROL: next_prdata = {24'h00_0000, timer_control};
        ADDR_COUNT_LOW: next_prdata = {24'h00_0000, count[7:0]};
        ADDR_COUNT_HIGH: next_prdata = {24'h00_0000, wide_mode ? high_buffer : count[15:8]};
        ADDR_STATUS: next_prdata = {31'h0000_0000, overflow_flag};
        ADDR_IRQ_ENABLE: next_prdata = {31'h0000_0000, overflow_irq_enable};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata <= next_prdata;
      pslverr <= next_slverr;
    end else if (!psel) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // control register, cleared at reset so the timer starts stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control <= TIMER_CONTROL_RESET;
    end else if (write_done && paddr == ADDR_CONTROL) begin
      timer_control <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq_enable <= 1'b0;
    end else if (write_done && paddr == ADDR_IRQ_ENABLE) begin
      overflow_irq_enable <= pwdata[BIT_OVERFLOW_IRQ_ENABLE];
    end
  end

  // high byte buffer: read snapshot and write staging in wide mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_buffer <= HIGH_BUFFER_RESET;
    end else if (wide_mode && wr_high) begin
      high_buffer <= pwdata[7:0];
    end else if (wide_mode && rd_low_setup) begin
      high_buffer <= count[15:8];
    end
  end

  // instruction cycle tick from the oscillator clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_div <= 2'b00;
    end else begin
      instr_div <= (instr_div == INSTR_DIV_LAST) ? 2'b00 : instr_div + 2'b01;
    end
  end

  assign instr_tick = (instr_div == INSTR_DIV_LAST);

  // sync bit always reaches the detector, which is enabled only with the external source
  ext_edge_detect u_ext_edge (
    .pclk(pclk),
    .presetn(presetn),
    .enable(ext_source),
    .bypass_sync(timer_control[BIT_EXT_SYNC_DISABLE]),
    .raw_clock(low_power_osc_enable ? osc_in_pin : ext_count_input),
    .rise(ext_rise)
  );

  // detector is disabled with the internal source, so sync bit has no effect
  assign source_tick = ext_source ? ext_rise : instr_tick;

  // prescaler: counter steps when the selected low bits are all ones
  assign count_step = timer_control[BIT_TIMER_RUN] && source_tick &&
    ((prescale_count & prescale_mask(timer_control[5:4])) ==
     prescale_mask(timer_control[5:4]));

  always_comb begin
    next_prescale = prescale_count;
    if (wr_low) begin
      next_prescale = 3'h0;
    end else if (timer_control[BIT_TIMER_RUN] && source_tick) begin
      next_prescale = count_step ? 3'h0 : prescale_count + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_count <= 3'h0;
    end else begin
      prescale_count <= next_prescale;
    end
  end

  // special event trigger from the compare unit
  assign special_event = compare_match && (capture_compare_mode_code == SPECIAL_EVENT_MODE);

  // count update: software write, then trigger, then step
  always_comb begin
    next_count = count;
    if (wr_low) begin
      next_count[7:0] = pwdata[7:0];
      if (wide_mode) begin
        next_count[15:8] = high_buffer;
      end
    end else if (wr_high && !wide_mode) begin
      next_count[15:8] = pwdata[7:0];
    end else if (wr_high) begin
      next_count = count;
    end else if (special_event) begin
      next_count = COUNT_RESET;
    end else if (count_step) begin
      next_count = count + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= COUNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  // overflow flag: set beats a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag <= 1'b0;
    end else if (count_step && count == COUNT_ALL_ONES && !wr_low && !wr_high && !special_event) begin
      overflow_flag <= 1'b1;
    end else if (wr_status && pwdata[BIT_OVERFLOW_FLAG]) begin
      overflow_flag <= 1'b0;
    end
  end

  // registered outputs toward the capture/compare units and pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value <= COUNT_RESET;
      ccp_uses_this_timer <= 1'b0;
      eccp_uses_this_timer <= 1'b0;
      osc_pins_force_input <= 1'b0;
      overflow_irq <= 1'b0;
    end else begin
      count_value <= next_count;
      ccp_uses_this_timer <= timer_control[BIT_CMP_CAP_TIMER_SEL_HI];
      eccp_uses_this_timer <= timer_control[BIT_CMP_CAP_TIMER_SEL_HI] ||
                              timer_control[BIT_CMP_CAP_TIMER_SEL_LO];
      osc_pins_force_input <= low_power_osc_enable;
      overflow_irq <= overflow_flag && overflow_irq_enable;
    end
  end

endmodule

// [testbench/timer_counter_sva.sv]
// port assertions for the prescaled timer/counter
module timer_counter_sva
  import timer_pkg::*;
(
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // far side
  input wire logic low_power_osc_enable,
  input wire logic osc_pins_force_input,
  input wire logic [3:0] capture_compare_mode_code,
  input wire logic compare_match,
  input wire logic [15:0] count_value,
  input wire logic ccp_uses_this_timer,
  input wire logic eccp_uses_this_timer
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire logic setup = psel && !penable;
  wire logic wr_any = psel && penable && pwrite;
  wire logic wr_done = wr_any && pready;
  wire logic trig = compare_match && capture_compare_mode_code == SPECIAL_EVENT_MODE;

  a_pready_one_cycle: assert property (setup |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  a_unmapped_slverr: assert property (setup && paddr > ADDR_IRQ_ENABLE |=> pslverr)
    else $error("no slave error on unmapped address");
  // read data is registered, so it clears one edge after the bus goes idle
  a_idle_rdata_zero: assert property (!psel |=> prdata == 32'h0)
    else $error("read data not cleared after bus idle");
  // control lands at the write edge, routing outputs follow one edge later
  a_ccp_route: assert property (wr_done && paddr == ADDR_CONTROL |-> ##2 ccp_uses_this_timer == $past(pwdata[6], 2))
    else $error("basic unit routing wrong");
  a_eccp_route: assert property (wr_done && paddr == ADDR_CONTROL |-> ##2
    eccp_uses_this_timer == ($past(pwdata[6], 2) || $past(pwdata[3], 2))) else $error("enhanced unit routing wrong");
  a_osc_pins_input: assert property ($past(presetn) |-> osc_pins_force_input == $past(low_power_osc_enable))
    else $error("oscillator pins not forced to inputs");
  a_trigger_clears: assert property (trig && !wr_any |=> count_value == 16'h0)
    else $error("special event did not clear count");
  a_step_by_one: assert property (!trig && !wr_any |=> 16'(count_value - $past(count_value)) <= 16'h1)
    else $error("count moved by more than one");
  a_write_wins: assert property (trig && wr_done && paddr == ADDR_COUNT_LOW |=>
    count_value[7:0] == $past(pwdata[7:0])) else $error("special event beat a count write");
endmodule

// [testbench/ccp_ext_model.sv]
// far-side model: compare unit trigger and external count clocks
module ccp_ext_model (
  // clock
  input wire logic pclk,
  // count clocks
  output logic ext_count_input,
  output logic osc_in_pin,
  // compare unit
  output logic [3:0] capture_compare_mode_code,
  output logic compare_match
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ext_count_input = 1'b0;
    osc_in_pin = 1'b0;
    capture_compare_mode_code = 4'h0;
    compare_match = 1'b0;
  end
  // the oscillator here never feeds the system clock, so the sync option stays usable
  // clocks idle low between bursts; four pclk per phase so both sync depths see every level
  task automatic pulses(int n, bit osc);
    for (int i = 0; i < 2 * n; i++) begin
      if (osc)
        osc_in_pin <= ~osc_in_pin;
      else
        ext_count_input <= ~ext_count_input;
      repeat (4) @(posedge pclk);
    end
  endtask
  // one-cycle match; extra edge lets the counter's update land
  task automatic fire(logic [3:0] code);
    capture_compare_mode_code <= code;
    compare_match <= 1'b1;
    @(posedge pclk);
    compare_match <= 1'b0;
    @(posedge pclk);
  endtask
endmodule

// [testbench/tb_top.sv]
// self-checking bench for the prescaled 16-bit timer/counter
module tb_top
  import timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic low_power_osc_enable = 1'b0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, ext_count_input, osc_in_pin, osc_pins_force_input, compare_match;
  logic ccp_uses_this_timer, eccp_uses_this_timer, overflow_irq;
  logic [3:0] capture_compare_mode_code;
  logic [15:0] count_value, v;
  int fail_count = 0;
  int n_checks = 0;
  int e;

  always #5 pclk = ~pclk;

  timer_counter uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .ext_count_input, .osc_in_pin, .low_power_osc_enable, .osc_pins_force_input, .capture_compare_mode_code,
    .compare_match, .count_value, .ccp_uses_this_timer, .eccp_uses_this_timer, .overflow_irq);
  ccp_ext_model far (.pclk, .ext_count_input, .osc_in_pin, .capture_compare_mode_code, .compare_match);

  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // idle edge at the end keeps the next setup off this release edge
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdchk(string what, logic [11:0] a, logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask
  function automatic int ticks(int cycles, int div);
    return cycles / (INSTR_CLK_DIV * div);
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #500us;
    fail_count++;
    stop_test();
  end

  initial begin
    void'($urandom(78722));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk("control", ADDR_CONTROL, 32'h0);
    check("count reset", count_value, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    check("slverr", err, 32'h1);
    v = 16'($urandom);
    wr(ADDR_COUNT_LOW, v[7:0]);
    wr(ADDR_COUNT_HIGH, v[15:8]);
    rdchk("low", ADDR_COUNT_LOW, v[7:0]);
    rdchk("high", ADDR_COUNT_HIGH, v[15:8]);
    wr(ADDR_CONTROL, 32'h80);
    wr(ADDR_COUNT_HIGH, 32'h5A);
    check("buffered high", count_value, v);
    wr(ADDR_COUNT_LOW, 32'hC3);
    check("wide write", count_value, 32'h5AC3);
    // staged high byte must be replaced by the snapshot taken on the low read
    wr(ADDR_COUNT_HIGH, 32'h11);
    rdchk("wide low", ADDR_COUNT_LOW, 32'hC3);
    rdchk("wide high", ADDR_COUNT_HIGH, 32'h5A);
    for (int s = 0; s < 4; s++) begin
      wr(ADDR_CONTROL, {24'h0, 1'b0, s[1], 2'b00, s[0], 3'b000});
      @(posedge pclk);
      check("ccp route", ccp_uses_this_timer, s[1]);
      check("eccp route", eccp_uses_this_timer, s[1] | s[0]);
    end
    // sync bit set on purpose: it must not matter with the internal source
    for (int p = 0; p < 4; p++) begin
      wr(ADDR_COUNT_HIGH, 32'h0);
      wr(ADDR_COUNT_LOW, 32'h0);
      wr(ADDR_CONTROL, {26'h0, 2'(p), 4'b0101});
      repeat (128 << p) @(posedge pclk);
      wr(ADDR_CONTROL, 32'h0);
      e = ticks(128 << p, 1 << p);
      check("prescale", count_value >= e - 1 && count_value <= e + 1, 32'h1);
      v = count_value;
      repeat (40) @(posedge pclk);
      check("stopped", count_value, v);
    end
    wr(ADDR_IRQ_ENABLE, 32'h1);
    wr(ADDR_COUNT_HIGH, 32'hFF);
    wr(ADDR_COUNT_LOW, 32'hFE);
    wr(ADDR_CONTROL, 32'h01);
    repeat (16) @(posedge pclk);
    wr(ADDR_CONTROL, 32'h0);
    check("wrap", count_value < 16'h8, 32'h1);
    rdchk("flag", ADDR_STATUS, 32'h1);
    check("irq", overflow_irq, 32'h1);
    wr(ADDR_IRQ_ENABLE, 32'h0);
    @(posedge pclk);
    check("irq masked", overflow_irq, 32'h0);
    wr(ADDR_STATUS, 32'h1);
    rdchk("flag clear", ADDR_STATUS, 32'h0);
    wr(ADDR_COUNT_LOW, 32'h77);
    far.fire(4'($urandom_range(10, 0)));
    check("other mode", count_value, 32'h77);
    far.fire(SPECIAL_EVENT_MODE);
    check("trigger", count_value, 32'h0);
    rdchk("no flag", ADDR_STATUS, 32'h0);
    v = 16'($urandom_range(255, 1));
    fork
      wr(ADDR_COUNT_LOW, v);
      begin
        @(posedge pclk);
        far.fire(SPECIAL_EVENT_MODE);
      end
    join
    check("write wins", count_value, v);
    // external source is reselected each pass so the first rise is skipped again
    for (int m = 0; m < 3; m++) begin
      low_power_osc_enable <= (m == 2);
      wr(ADDR_COUNT_LOW, 32'h0);
      wr(ADDR_CONTROL, {29'h0, m[0], 2'b11});
      far.pulses(5, m == 2);
      repeat (6) @(posedge pclk);
      check("ext count", count_value, 32'h4);
      check("osc inputs", osc_pins_force_input, m == 2);
      wr(ADDR_CONTROL, 32'h0);
    end
    stop_test();
  end
endmodule

bind timer_counter timer_counter_sva sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .low_power_osc_enable, .osc_pins_force_input, .capture_compare_mode_code, .compare_match,
  .count_value, .ccp_uses_this_timer, .eccp_uses_this_timer);
